// ===== verilog/sar_ctl_pkg.sv
// What this block does
// - Parallel mode: shared pin is result bit 11.
// - Serial external clock: shared pin is error flag.
// - Unfinished slave read at completion: drop, pulse flag.
// - Result bits 12 to 15 driven at all times except while reset is applied.
// - Busy high from start until result latched.
// - Output bus bits 0 to 10 enabled only with select and read low.
// - Chip select gates the external serial clock.
// - Reset held high aborts any conversion.
// - Power-down finishes current conversion, then blocks starts.
// - Start falling edge holds sample and converts.
// - Low-power mode: start still low after acquisition converts.
// - Clock source select sets serial clock direction.
// - Both mode selects low gives normal mode.
package sar_ctl_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned RES_BITS       = 16;
  localparam int unsigned CONV_NS        = 1600;
  localparam int unsigned ACQ_NS         = 400;
  localparam int unsigned LP_WAKE_NS     = 400;
  localparam int unsigned CONV_CYC       = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACQ_CYC        = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LP_WAKE_CYC    = (LP_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_DIV       = 8;
  localparam int unsigned CNT_W          = 12;
  localparam logic [4:0]  BIT_CNT_RST    = 5'h00;
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam int unsigned ERR_BIT        = 11;
  localparam int unsigned SDOUT_BIT      = 8;
  localparam int unsigned SCLK_BIT       = 9;
  typedef enum logic [1:0] {
    ST_ACQ  = 2'b00,
    ST_CONV = 2'b01,
    ST_DOWN = 2'b10
  } conv_state_e;
endpackage

// ===== verilog/sar_sync2.sv
module sar_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule // sar_sync2

// ===== verilog/sar_adc_conversion_control.sv
module sar_adc_conversion_control
  import sar_ctl_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reset_pin,
  input  wire logic        i_conversion_start_n,
  input  wire logic        i_power_down,
  input  wire logic        i_low_power_sel,
  input  wire logic        i_fast_rate_sel,
  input  wire logic        i_serial_parallel_select,
  input  wire logic        i_clock_source_select,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_sclk_in,
  input  wire logic [15:0] i_sample,
  output logic             o_busy,
  output logic             o_low_power_active,
  output logic             o_hold,
  output logic [15:0]      o_data,
  output logic [15:0]      o_data_oe,
  output logic             o_incomplete_read_flag
);
  // Pins from the host are asynchronous: resync all but the two mode selects together.
  // Active-low pins pass the synchroniser inverted, so that its cleared
  // state reads as idle and no select or read shows up after reset.
  localparam logic [7:0] IDLE_FLIP = 8'h46;
  logic [7:0] pin_raw;
  logic [7:0] pin_s;
  assign pin_raw = {i_reset_pin, i_conversion_start_n, i_power_down,
                    i_serial_parallel_select, i_clock_source_select,
                    i_cs_n, i_rd_n, i_sclk_in} ^ IDLE_FLIP;

  sar_sync2 #(.W(8)) u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   (pin_raw),
    .o_sync    (pin_s)
  );

  logic rst_pin, cnv_n, pd, ser, ext, cs_n, rd_n, sclk;
  assign {rst_pin, cnv_n, pd, ser, ext, cs_n, rd_n, sclk} = pin_s ^ IDLE_FLIP;

  conv_state_e       state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              cnv_prev_q, sclk_prev_q;
  logic              busy_q, busy_d;
  logic [15:0]       result_q, result_d;
  logic [15:0]       shift_q, shift_d;
  logic [4:0]        bits_q, bits_d;
  logic              err_q, err_d;
  logic              hold_q, hold_d;
  logic [15:0]       data_q, data_d;
  logic [15:0]       oe_q, oe_d;
  logic [3:0]        div_q, div_d;
  logic              isclk_q, isclk_d;
  logic              lowpow_q, lowpow_d;

  // Counts from the package are wider than the counter; the helper cuts
  // them in one place for every comparison against the counter.
  function automatic logic at_count(input logic [CNT_W-1:0] c,
                                    input int unsigned       n);
    return c == CNT_W'(n);
  endfunction

  logic cnv_fall, sclk_rise, read_en, slave, impulse, start, done;
  assign cnv_fall  = cnv_prev_q & ~cnv_n;
  assign read_en   = ~cs_n & ~rd_n;
  assign slave     = ser & ext;
  // An external clock edge counts only while selected.
  assign sclk_rise = slave & ~cs_n & sclk & ~sclk_prev_q;
  assign impulse   = i_low_power_sel & ~i_fast_rate_sel;
  assign done      = (state_q == ST_CONV) && at_count(cnt_q, CONV_CYC - 1);

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    busy_d   = busy_q;
    hold_d   = hold_q;
    result_d = result_q;
    shift_d  = shift_q;
    bits_d   = bits_q;
    err_d    = 1'b0;
    div_d    = div_q + 4'h1;
    isclk_d  = isclk_q;
    lowpow_d = impulse && (state_q != ST_CONV);
    start    = 1'b0;
    case (state_q)
      ST_ACQ: begin
        if (!at_count(cnt_q, ACQ_CYC)) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (pd) begin
          state_d = ST_DOWN;
        end else if (at_count(cnt_q, ACQ_CYC)) begin
          // Normal mode starts only on an edge; low-power also on a level.
          start = cnv_fall || (impulse && !cnv_n);
        end
        if (start) begin
          state_d = ST_CONV;
          cnt_d   = '0;
          busy_d  = 1'b1;
          hold_d  = 1'b1;
        end
      end
      ST_CONV: begin
        cnt_d = cnt_q + 1'b1;
        if (done) begin
          // A pending slave read is lost when the new result lands.
          if (slave && bits_q != BIT_CNT_RST) begin
            err_d = 1'b1;
          end
          result_d = i_sample;
          shift_d  = i_sample;
          bits_d   = BIT_CNT_RST;
          busy_d   = 1'b0;
          hold_d   = 1'b0;
          cnt_d    = '0;
          state_d  = pd ? ST_DOWN : ST_ACQ;
        end
      end
      ST_DOWN: begin
        cnt_d = '0;
        if (!pd) begin
          state_d = ST_ACQ;
        end
      end
      default: begin
        state_d = ST_ACQ;
        cnt_d   = '0;
      end
    endcase
    // Internal serial clock is a divided tick driven out when master.
    if (div_q == 4'(SCLK_DIV - 1)) begin
      div_d   = 4'h0;
      isclk_d = ~isclk_q;
    end
    if (sclk_rise || (ser && !ext && read_en && div_q == 4'h0
                      && isclk_q)) begin
      // The edge that meets a freshly loaded result must not shift it.
      if (!done) begin
        shift_d = {shift_q[14:0], 1'b0};
        bits_d  = (bits_q == 5'd15) ? BIT_CNT_RST : bits_q + 5'd1;
      end
    end
  end

  always_comb begin
    data_d = result_q;
    oe_d   = '0;
    if (read_en) begin
      oe_d = 16'hffff;
      if (ser) begin
        data_d            = 16'h0000;
        data_d[15:12]     = result_q[15:12];
        data_d[SDOUT_BIT] = shift_q[15];
        data_d[SCLK_BIT]  = isclk_q;
        oe_d[SCLK_BIT]    = ~ext;
        oe_d[7:0]         = 8'h00;
        oe_d[10]          = 1'b0;
        oe_d[ERR_BIT]     = ext;
      end
    end
    if (!ser) begin
      data_d[ERR_BIT] = result_q[ERR_BIT];
    end else begin
      data_d[ERR_BIT] = err_q;
      oe_d[ERR_BIT]   = ext;
    end
    oe_d[15:12] = 4'hf;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || rst_pin) begin
      state_q     <= ST_ACQ;
      cnt_q       <= '0;
      busy_q      <= 1'b0;
      hold_q      <= 1'b0;
      result_q    <= RESULT_RST;
      shift_q     <= RESULT_RST;
      bits_q      <= BIT_CNT_RST;
      err_q       <= 1'b0;
      cnv_prev_q  <= 1'b1;
      sclk_prev_q <= 1'b0;
      div_q       <= 4'h0;
      isclk_q     <= 1'b0;
      lowpow_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      busy_q      <= busy_d;
      hold_q      <= hold_d;
      result_q    <= result_d;
      shift_q     <= shift_d;
      bits_q      <= bits_d;
      err_q       <= err_d;
      cnv_prev_q  <= cnv_n;
      sclk_prev_q <= sclk;
      div_q       <= div_d;
      isclk_q     <= isclk_d;
      lowpow_q    <= lowpow_d || (state_d == ST_DOWN);
    end
  end

  // The pin stage is registered on its own; it follows the converter
  // state one cycle later, while busy, hold and the flag change with it.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || rst_pin) begin
      data_q <= RESULT_RST;
      oe_q   <= 16'h0000;
    end else begin
      data_q <= data_d;
      oe_q   <= oe_d;
    end
  end

  assign o_busy                 = busy_q;
  assign o_hold                 = hold_q;
  assign o_low_power_active     = lowpow_q;
  assign o_data                 = data_q;
  assign o_data_oe              = oe_q;
  assign o_incomplete_read_flag = err_q;
endmodule // sar_adc_conversion_control

// ===== dv/sar_ctl_sva.sv
module sar_ctl_sva (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic        i_reset_pin,
  input wire logic        i_power_down,
  input wire logic        i_serial_parallel_select,
  input wire logic        i_cs_n,
  input wire logic        i_rd_n,
  input wire logic        o_busy,
  input wire logic        o_hold,
  input wire logic [15:0] o_data_oe,
  input wire logic        o_incomplete_read_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // The block keeps its reset two cycles past the pin through the
  // synchroniser, so the checks stay off until that tail has passed.
  logic [2:0] pin_hist_q = 3'h0;
  always @(posedge i_mclk) begin
    pin_hist_q <= {pin_hist_q[1:0], i_reset_pin};
  end
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst || i_reset_pin || (pin_hist_q != 3'h0));
  hold_busy_a: assert property (o_hold == o_busy)
    else $error("hold and busy differ");
  pin_abort_a: assert property (disable iff (i_sys_rst)
    i_reset_pin [*3] |=> !o_busy) else $error("busy kept in reset");
  conv_len_a: assert property ($rose(o_busy) |->
    ##190 o_busy ##[1:12] !o_busy) else $error("conversion length");
  pd_block_a: assert property (i_power_down [*5] |->
    !$rose(o_busy)) else $error("start in power-down");
  par_drive_a: assert property ((!i_cs_n && !i_rd_n &&
    !i_serial_parallel_select) [*4] |-> o_data_oe == 16'hffff)
    else $error("bus not driven");
  par_float_a: assert property (((i_cs_n || i_rd_n) &&
    !i_serial_parallel_select) [*4] |-> o_data_oe == 16'hf000)
    else $error("bus not released");
  top_drive_a: assert property (1'b1 [*4] |->
    o_data_oe[15:12] == 4'hf) else $error("top bits released");
  flag_busy_a: assert property ($rose(o_incomplete_read_flag) |->
    $fell(o_busy) && i_serial_parallel_select)
    else $error("flag out of place");
endmodule // sar_ctl_sva
bind sar_adc_conversion_control sar_ctl_sva chk (
  .i_mclk                   (i_mclk),
  .i_sys_rst                (i_sys_rst),
  .i_reset_pin              (i_reset_pin),
  .i_power_down             (i_power_down),
  .i_serial_parallel_select (i_serial_parallel_select),
  .i_cs_n                   (i_cs_n),
  .i_rd_n                   (i_rd_n),
  .o_busy                   (o_busy),
  .o_hold                   (o_hold),
  .o_data_oe                (o_data_oe),
  .o_incomplete_read_flag   (o_incomplete_read_flag)
);

// ===== dv/sar_host_link.sv
module sar_host_link (
  input  wire logic i_mclk,
  input  wire logic i_frame,
  input  wire logic i_free,
  output logic      o_cs_n = 1'b1,
  output logic      o_sclk = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_q = 4'h0;
  logic       run;
  // The clock rests low between frames unless asked to run free; a free
  // clock with the select high must leave the block untouched.
  assign run = i_frame || i_free;
  always @(posedge i_mclk) begin
    o_cs_n <= !i_frame;
    div_q <= (!run || div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
    if (!run)
      o_sclk <= 1'b0;
    else if (div_q == 4'h9)
      o_sclk <= !o_sclk;
  end
endmodule // sar_host_link

// ===== dv/sar_adc_conversion_control_tb.sv
module sar_adc_conversion_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, rpin, st_n, pd, lp, sp, ext, rd_n, frame;
  logic        busy, hold, flag, cs_n, sclk, lpa, free;
  logic [15:0] smp, data, oe;
  int          fail_count, checks_done, cyc, nflag;
  sar_host_link host (.i_mclk(mclk), .i_frame(frame), .i_free(free),
    .o_cs_n(cs_n), .o_sclk(sclk));
  sar_adc_conversion_control dut (.i_mclk(mclk), .i_sys_rst(rst),
    .i_reset_pin(rpin), .i_conversion_start_n(st_n), .i_power_down(pd),
    .i_low_power_sel(lp), .i_fast_rate_sel(1'b0),
    .i_serial_parallel_select(sp), .i_clock_source_select(ext),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_sclk_in(sclk), .i_sample(smp),
    .o_busy(busy), .o_low_power_active(lpa), .o_hold(hold), .o_data(data),
    .o_data_oe(oe), .o_incomplete_read_flag(flag));
  task complete_run;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wb(input logic v);
    #1;
    for (int k = 0; k < 400 && busy !== v; k++) begin
      @(posedge mclk);
      #1;
    end
    chk(16'(busy), 16'(v));
  endtask
  // Waits out acquisition first, since earlier edges are ignored.
  task go;
    repeat (60) @(posedge mclk);
    st_n <= 1'b0;
    repeat (6) @(posedge mclk);
    st_n <= 1'b1;
  endtask
  task rd(input logic v);
    @(posedge mclk);
    rd_n <= !v;
    frame <= v;
  endtask
  task t_par;
    smp <= 16'ha9c3;
    go();
    wb(1'b1);
    chk(16'(hold), 16'h1);
    wb(1'b0);
    rd(1'b1);
    repeat (6) @(posedge mclk);
    #1;
    chk(data, 16'ha9c3);
    chk(oe, 16'hffff);
    rd(1'b0);
    repeat (6) @(posedge mclk);
    #1;
    chk(oe, 16'hf000);
  endtask
  task t_pd;
    go();
    wb(1'b1);
    @(posedge mclk);
    pd <= 1'b1;
    wb(1'b0);
    go();
    repeat (20) @(posedge mclk);
    #1;
    chk(16'(busy), 16'h0);
    chk(16'(lpa), 16'h1);
    @(posedge mclk);
    pd <= 1'b0;
  endtask
  task t_rst;
    go();
    wb(1'b1);
    @(posedge mclk);
    rpin <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(16'(busy), 16'h0);
    @(posedge mclk);
    rpin <= 1'b0;
  endtask
  task t_imp;
    @(posedge mclk);
    lp <= 1'b1;
    repeat (60) @(posedge mclk);
    st_n <= 1'b0;
    wb(1'b1);
    wb(1'b0);
    wb(1'b1);
    @(posedge mclk);
    st_n <= 1'b1;
    lp <= 1'b0;
    wb(1'b0);
  endtask
  task t_err;
    chk(16'(nflag), 16'h0);
    @(posedge mclk);
    sp <= 1'b1;
    ext <= 1'b1;
    free <= 1'b1;
    go();
    wb(1'b0);
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(nflag), 16'h0);
    @(posedge mclk);
    free <= 1'b0;
    rd(1'b1);
    repeat (6) @(posedge mclk);
    #1;
    chk(oe, 16'hf900);
    repeat (94) @(posedge mclk);
    rd(1'b0);
    nflag = 0;
    go();
    wb(1'b1);
    wb(1'b0);
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(nflag), 16'h1);
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (flag === 1'b1)
      nflag++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {rst, rpin, st_n, pd, lp, sp, ext, rd_n, frame, free} = 10'h284;
    smp = 16'h0000;
    fail_count = 0;
    checks_done = 0;
    cyc = 0;
    nflag = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_par();
    t_pd();
    t_rst();
    t_imp();
    t_err();
    complete_run();
  end
endmodule // sar_adc_conversion_control_tb
